// ---- inc/sar_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the serial audio link
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
`define SAR_SAMPLE_W 24
`define SAR_ERR_ADDR 8'h02
`define SAR_SFC_ADDR 8'h04
`define SAR_SFC_RESET 8'h05
`define SAR_SFC_WL_LSB 0
`define SAR_SFC_FMT_LSB 2
`define SAR_ERR_OVF_BIT 0
`define SAR_HOST_CTRL 2'h0
`define SAR_HOST_LEFT 2'h1
`define SAR_HOST_RIGHT 2'h2
`define SAR_HOST_STAT 2'h3
`define SAR_HOST_CTRL_RESET 7'h4A
`define SAR_CTRL_EN_BIT 0
`define SAR_CTRL_FMT_LSB 1
`define SAR_CTRL_WL_LSB 3
`define SAR_CTRL_RATIO_LSB 5
`define SAR_BCLK_HALF 4
`endif

// ---- inc/sar_pkg.sv ----
// Types and shared decoders of the serial audio link
package sar_pkg;
    typedef enum logic [1:0] {
        SAR_RIGHT_JUSTIFIED = 2'b00,
        SAR_STD_I2S = 2'b01,
        SAR_LEFT_JUSTIFIED = 2'b10
    } sar_fmt_e;

    // Word length code: 0 -> 16, 1 -> 24, 2 -> 20, 3 falls back to 24
    function automatic logic [5:0] sar_wl_bits(input logic [1:0] code);
        unique case (code)
            2'h0: return 6'h10;
            2'h2: return 6'h14;
            default: return 6'h18;
        endcase
    endfunction

    // Bit clocks per channel slot: ratio 32, 48 or 64 times the sample rate
    function automatic logic [5:0] sar_slot_bits(input logic [1:0] code);
        unique case (code)
            2'h0: return 6'h10;
            2'h1: return 6'h18;
            default: return 6'h20;
        endcase
    endfunction
endpackage

// ---- inc/sar_link_if.sv ----
// Three-wire serial audio link between source and receiver
`timescale 1ns/10ps
interface sar_link_if;
    logic bit_clk;
    logic frame_channel_select;
    logic serial_audio_in;
    modport src (
        output bit_clk,
        output frame_channel_select,
        output serial_audio_in
    );
    modport rcv (
        input bit_clk,
        input frame_channel_select,
        input serial_audio_in
    );
endinterface

// ---- logic/sar_rx.sv ----
// Stereo serial audio receiver: samples the link, frames words, buffers pairs
`timescale 1ns/10ps
`include "sar_cfg.svh"

//Function
// R01 - Standard framing: select low left, high right
// R02 - Bit clock 32, 48 or 64 per sample
// R03 - Standard framing: capture starts one bit later
// R04 - MSB first, sampled on rising bit clock
// R05 - Standard/left-justified: ignore trailing unused bits
// R06 - Justified framings: select high left, low right
// R07 - Left-justified: MSB with select change
// R08 - Right-justified 24-bit: data eight bits late
// R09 - Right-justified: LSB just before select change
// R10 - Right-justified: ignore leading unused bits
// R11 - Samples are signed, sign kept on alignment
// R12 - Ratio 48 carries a 24-bit word
// R13 - Format register at 0x04, resets 0x05
// R14 - Accept 16, 20 and 24-bit words
// R15 - One-cycle strobe per completed stereo pair
// R16 - Select change restarts the bit counter
module sar_rx
    import sar_pkg::*;
#(
    parameter int SAMPLE_W = `SAR_SAMPLE_W
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    sar_link_if.rcv link,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic pair_strobe,
    output logic out_valid,
    input wire logic out_ready,
    output logic [SAMPLE_W-1:0] out_left,
    output logic [SAMPLE_W-1:0] out_right
);
    // Left-aligns the k received bits so the sign bit lands on the MSB
    function automatic logic [SAMPLE_W-1:0] align(input logic [31:0] a, input logic [5:0] k);
        logic [31:0] sh;
        sh = a << (6'(SAMPLE_W) - k);
        return sh[SAMPLE_W-1:0];
    endfunction

    logic [2:0] sync1;
    logic [2:0] sync2;
    logic bclk_q;
    logic fcs_q;
    logic fcs_qq;
    logic [7:0] serial_format_config;
    logic overflow;
    logic [5:0] cnt;
    logic [5:0] ncap;
    logic [31:0] acc;
    logic [SAMPLE_W-1:0] left_hold;
    logic spare_v;
    logic [2*SAMPLE_W-1:0] spare;

    wire rise = sync2[2] & ~bclk_q;
    wire fcs_s = sync2[1];
    wire sd_s = sync2[0];
    wire sar_fmt_e fmt = sar_fmt_e'(serial_format_config[`SAR_SFC_FMT_LSB +: 2]);
    wire is_right = (fmt == SAR_RIGHT_JUSTIFIED);
    wire is_left = (fmt == SAR_LEFT_JUSTIFIED);
    wire is_std = !is_right && !is_left;
    wire [5:0] wl = sar_wl_bits(serial_format_config[`SAR_SFC_WL_LSB +: 2]); // [R14] [R12]
    // Standard framing is treated as left-justified with the select delayed one bit
    wire eff_now = is_std ? fcs_q : fcs_s; // [R03]
    wire eff_last = is_std ? fcs_qq : fcs_q;
    wire slot_edge = rise && (eff_now != eff_last);
    wire old_left = is_std ? ~eff_last : eff_last; // [R01] [R06]
    // Right-justified keeps shifting; the last wl bits before the change survive
    wire in_window = is_right || (cnt < wl); // [R05] [R10]
    wire [5:0] keep = is_right ? wl : ncap; // [R09] [R08]
    wire [SAMPLE_W-1:0] word = align(acc, keep); // [R11]
    wire push = slot_edge && !old_left; // [R15]
    wire [2*SAMPLE_W-1:0] push_data = {left_hold, word};
    wire pop = out_valid && out_ready;
    wire drop = push && !pop && out_valid && spare_v;
    wire err_clear = reg_wr && (reg_addr == `SAR_ERR_ADDR) && reg_wdata[`SAR_ERR_OVF_BIT];
    wire [7:0] rd_mux = (reg_addr == `SAR_SFC_ADDR) ? serial_format_config :
                        (reg_addr == `SAR_ERR_ADDR) ? {7'h00, overflow} : 8'h00;

    // Link pins come from another domain: two flops before any logic
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            bclk_q <= 1'b0;
        end
        else
        begin
            sync1 <= {link.bit_clk, link.frame_channel_select, link.serial_audio_in};
            sync2 <= sync1;
            bclk_q <= sync2[2];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_format_config <= `SAR_SFC_RESET; // [R13]
            overflow <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            if (reg_wr && reg_addr == `SAR_SFC_ADDR)
            begin
                serial_format_config <= reg_wdata; // [R13]
            end
            // A drop in the same cycle as a clear stays flagged
            overflow <= drop || (overflow && !err_clear);
            reg_rdata <= rd_mux;
        end
    end

    // Slot framing works for any ratio: nothing assumes the slot length
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fcs_q <= 1'b0;
            fcs_qq <= 1'b0;
            cnt <= 6'h00;
            ncap <= 6'h00;
            acc <= 32'h0000_0000;
        end
        else if (rise) // [R04]
        begin
            fcs_q <= fcs_s;
            fcs_qq <= fcs_q;
            if (slot_edge)
            begin
                acc <= {31'h0, sd_s}; // [R07]
                cnt <= 6'h01; // [R16]
                ncap <= 6'h01;
            end
            else
            begin
                if (cnt != 6'h3F)
                begin
                    cnt <= cnt + 6'h01; // [R02]
                end
                if (in_window)
                begin
                    acc <= {acc[30:0], sd_s}; // [R04]
                    if (ncap != 6'h3F)
                    begin
                        ncap <= ncap + 6'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            left_hold <= '0;
            pair_strobe <= 1'b0;
        end
        else
        begin
            if (slot_edge && old_left)
            begin
                left_hold <= word;
            end
            pair_strobe <= push; // [R15]
        end
    end

    // Two-entry buffer: head register drives the ports, spare absorbs one stall
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_valid <= 1'b0;
            {out_left, out_right} <= '0;
            spare_v <= 1'b0;
            spare <= '0;
        end
        else if (pop)
        begin
            if (spare_v)
            begin
                {out_left, out_right} <= spare;
                spare_v <= push;
                spare <= push_data;
            end
            else
            begin
                out_valid <= push;
                {out_left, out_right} <= push_data;
            end
        end
        else if (push)
        begin
            if (!out_valid)
            begin
                out_valid <= 1'b1;
                {out_left, out_right} <= push_data;
            end
            else if (!spare_v)
            begin
                spare_v <= 1'b1;
                spare <= push_data;
            end
        end
    end
endmodule // sar_rx

// ---- logic/sar_tx_host.sv ----
// Serial audio source: Avalon-MM register front end and link serializer
`timescale 1ns/10ps
`include "sar_cfg.svh"

module sar_tx_host
    import sar_pkg::*;
#(
    parameter int SAMPLE_W = `SAR_SAMPLE_W,
    parameter int BCLK_HALF = `SAR_BCLK_HALF
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    sar_link_if.src link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // Bit for slot position s of a left-aligned sample word
    function automatic logic tx_bit(input logic [SAMPLE_W-1:0] w, input logic [5:0] s,
                                    input logic [5:0] wl, input logic [5:0] slot,
                                    input logic right);
        int idx;
        idx = right ? int'(s) - (int'(slot) - int'(wl)) : int'(s);
        if (idx >= 0 && idx < int'(wl))
            return w[SAMPLE_W-1-idx];
        return 1'b0;
    endfunction

    logic [6:0] ctrl;
    logic [SAMPLE_W-1:0] left_hold;
    logic [SAMPLE_W-1:0] pend_l;
    logic [SAMPLE_W-1:0] pend_r;
    logic pend_v;
    logic [SAMPLE_W-1:0] cur_l;
    logic [SAMPLE_W-1:0] cur_r;
    logic [7:0] div;
    logic bclk;
    logic fcs;
    logic sd;
    logic [5:0] pos;

    wire en = ctrl[`SAR_CTRL_EN_BIT];
    wire sar_fmt_e fmt = sar_fmt_e'(ctrl[`SAR_CTRL_FMT_LSB +: 2]);
    wire is_right = (fmt == SAR_RIGHT_JUSTIFIED);
    wire is_std = !is_right && (fmt != SAR_LEFT_JUSTIFIED);
    wire [5:0] wl = sar_wl_bits(ctrl[`SAR_CTRL_WL_LSB +: 2]);
    wire [5:0] slot = sar_slot_bits(ctrl[`SAR_CTRL_RATIO_LSB +: 2]); // [R02] [R12]
    wire [6:0] frame = {slot, 1'b0};
    wire tick = (div == 8'(BCLK_HALF - 1));
    wire fall = tick && bclk;
    wire [5:0] npos = (7'(pos) >= frame - 7'h01) ? 6'h00 : pos + 6'h01;
    wire load = (npos == 6'h00);
    wire ch = (npos >= slot);
    wire [5:0] s = ch ? npos - slot : npos;
    wire [6:0] nn = 7'(npos) + 7'h01;
    // Standard framing moves the select one bit ahead of the MSB
    wire ch_ahead = (nn >= 7'(slot)) && (nn < frame); // [R03]
    wire [SAMPLE_W-1:0] next_l = load ? (pend_v ? pend_l : '0) : cur_l;
    wire [SAMPLE_W-1:0] next_r = load ? (pend_v ? pend_r : '0) : cur_r;
    wire next_fcs = is_std ? ch_ahead : ~ch; // [R01] [R06] [R07]
    wire next_sd = tx_bit(ch ? next_r : next_l, s, wl, slot, is_right); // [R04] [R08] [R09]
    wire [1:0] sel = avs_address[3:2];
    wire req = avs_read || avs_write;
    // A second pair waits in waitrequest until the first is on the link
    wire blocked = avs_write && (sel == `SAR_HOST_RIGHT) && pend_v;
    wire done = req && !avs_waitrequest;
    wire [31:0] rd_mux = (sel == `SAR_HOST_CTRL) ? {25'h0, ctrl} :
                         (sel == `SAR_HOST_LEFT) ? 32'(left_hold) :
                         (sel == `SAR_HOST_STAT) ? {30'h0, en, pend_v} : 32'h0000_0000;

    assign link.bit_clk = bclk;
    assign link.frame_channel_select = fcs;
    assign link.serial_audio_in = sd;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if (done)
        begin
            avs_waitrequest <= 1'b1;
        end
        else if (req && !blocked)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl <= `SAR_HOST_CTRL_RESET;
            left_hold <= '0;
            pend_l <= '0;
            pend_r <= '0;
            pend_v <= 1'b0;
        end
        else
        begin
            if (fall && load)
            begin
                pend_v <= 1'b0;
            end
            if (done && avs_write)
            begin
                if (sel == `SAR_HOST_CTRL)
                begin
                    ctrl <= avs_writedata[6:0];
                end
                if (sel == `SAR_HOST_LEFT)
                begin
                    left_hold <= avs_writedata[SAMPLE_W-1:0];
                end
                if (sel == `SAR_HOST_RIGHT)
                begin
                    pend_l <= left_hold;
                    pend_r <= avs_writedata[SAMPLE_W-1:0];
                    pend_v <= 1'b1;
                end
            end
        end
    end

    // Link changes on the falling bit clock so the receiver samples mid-bit
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div <= 8'h00;
            bclk <= 1'b0;
            fcs <= 1'b0;
            sd <= 1'b0;
            pos <= 6'h3F;
            cur_l <= '0;
            cur_r <= '0;
        end
        else if (!en)
        begin
            div <= 8'h00;
            bclk <= 1'b0;
            fcs <= 1'b0;
            sd <= 1'b0;
            pos <= 6'(frame - 7'h01);
        end
        else
        begin
            div <= tick ? 8'h00 : div + 8'h01;
            if (tick)
            begin
                bclk <= ~bclk;
            end
            if (fall)
            begin
                pos <= npos;
                cur_l <= next_l;
                cur_r <= next_r;
                fcs <= next_fcs;
                sd <= next_sd;
            end
        end
    end
endmodule // sar_tx_host

// ---- tb/sar_link_properties.sv ----
// Timing properties of the three-wire serial audio link
`timescale 1ns/10ps
module sar_link_properties
#(
    parameter int BCLK_HALF = 4
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bit_clk,
    input wire logic frame_channel_select,
    input wire logic serial_audio_in
);
    localparam int BIT_P = 2 * BCLK_HALF;
    localparam int HALF_1 = BCLK_HALF + 1;
    logic bclk_q;
    logic sel_q;
    logic [6:0] rise_cnt;
    logic [6:0] last_n;
    logic [1:0] seen;
    wire logic bclk_rise = bit_clk && !bclk_q;
    wire logic sel_chg = frame_channel_select != sel_q;
    wire logic [6:0] next_rise_cnt = sel_chg ? 7'h00 : rise_cnt + {6'h00, bclk_rise};
    // The first slot after enable may be one bit long, so it is only recorded
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bclk_q <= 1'h0;
            sel_q <= 1'h0;
            rise_cnt <= 7'h00;
            last_n <= 7'h00;
            seen <= 2'h0;
        end
        else
        begin
            bclk_q <= bit_clk;
            sel_q <= frame_channel_select;
            rise_cnt <= next_rise_cnt;
            if (sel_chg)
            begin
                last_n <= rise_cnt;
                seen <= (seen == 2'h2) ? seen : seen + 2'h1;
            end
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    AST_BCLK_HIGH: assert property (
        $fell(bit_clk) |-> $past(bit_clk, BCLK_HALF) && !$past(bit_clk, HALF_1))
        else $error("bit clock high phase length wrong");
    AST_BCLK_RISE: assert property (
        $rose(bit_clk) |-> ##BIT_P $rose(bit_clk))
        else $error("bit clock period wrong");
    AST_BCLK_LOW: assert property (
        $fell(bit_clk) |-> ##BCLK_HALF $rose(bit_clk))
        else $error("bit clock low phase length wrong");
    AST_SEL_IN_LOW: assert property (
        $changed(frame_channel_select) |-> !bit_clk)
        else $error("select changed while bit clock high");
    AST_DATA_IN_LOW: assert property (
        $changed(serial_audio_in) |-> !bit_clk)
        else $error("data changed while bit clock high");
    AST_HOLD_HIGH: assert property (
        $rose(bit_clk) |=> ($stable(serial_audio_in) && $stable(frame_channel_select)) [*2])
        else $error("link lines moved after rising bit clock");
    AST_SLOT_LEN: assert property (
        sel_chg && seen != 2'h0 |-> rise_cnt inside {7'h10, 7'h18, 7'h20})
        else $error("slot length not 16, 24 or 32 bits");
    AST_SLOT_EQUAL: assert property (
        sel_chg && seen == 2'h2 |-> rise_cnt == last_n)
        else $error("left and right slots differ");
endmodule // sar_link_properties

// ---- tb/tb_top.sv ----
// Bench: register-driven audio source linked to the serial audio receiver
`timescale 1ns/10ps
`include "sar_cfg.svh"
module tb_top import sar_pkg::*;;
    logic sys_clk;
    logic rst_b;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic pair_strobe;
    logic out_valid;
    logic out_ready;
    logic [23:0] out_left;
    logic [23:0] out_right;
    logic [23:0] cap_l[$];
    logic [23:0] cap_r[$];
    logic stall_q;
    logic strobe_q;
    logic [47:0] head_q;
    int n_strobe;
    int mismatches;
    int n_tests;
    sar_link_if link();
    sar_tx_host #(.BCLK_HALF(`SAR_BCLK_HALF)) sar_tx_host_i (.sys_clk, .rst_b, .link(link),
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    sar_rx sar_rx_i (.sys_clk, .rst_b, .link(link), .reg_wr, .reg_addr, .reg_wdata,
        .reg_rdata, .pair_strobe, .out_valid, .out_ready, .out_left, .out_right);
    sar_link_properties #(.BCLK_HALF(`SAR_BCLK_HALF)) sar_link_properties_i (.sys_clk,
        .rst_b, .bit_clk(link.bit_clk), .frame_channel_select(link.frame_channel_select),
        .serial_audio_in(link.serial_audio_in));
    always #5 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Output monitor: a stalled head must hold, a strobe lasts one cycle
    always @(posedge sys_clk)
    begin
        if (rst_b)
        begin
            if (out_valid === 1'h1 && out_ready === 1'h1)
            begin
                cap_l.push_back(out_left);
                cap_r.push_back(out_right);
            end
            if (stall_q)
                check(out_valid === 1'h1 && {out_left, out_right} === head_q, 32'h1, "head");
            if (strobe_q)
                check(pair_strobe, 32'h0, "strobe width");
            n_strobe += (pair_strobe === 1'h1);
        end
        stall_q <= rst_b && out_valid === 1'h1 && out_ready === 1'h0;
        strobe_q <= rst_b && pair_strobe === 1'h1;
        head_q <= {out_left, out_right};
    end
    task automatic do_reset();
        rst_b <= 1'h0;
        repeat (3) @(posedge sys_clk);
        cap_l.delete();
        cap_r.delete();
        n_strobe = 0;
        rst_b <= 1'h1;
        @(posedge sys_clk);
    endtask
    // Slow answers are normal: a right push waits for the next frame start
    task automatic avs_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        int n;
        n = 0;
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'h0 && n < 4000);
        rdata = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge sys_clk);
        check(n < 4000, 32'h1, "bus answer");
    endtask
    task automatic rx_wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rx_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        repeat (2) @(posedge sys_clk);
        check(reg_rdata, exp, what);
    endtask
    task automatic t_regs();
        logic [31:0] rd;
        do_reset();
        rx_chk(`SAR_SFC_ADDR, `SAR_SFC_RESET, "format reset");
        rx_chk(`SAR_ERR_ADDR, 8'h00, "error reset");
        rx_chk(8'h10, 8'h00, "unmapped");
        rx_wr(`SAR_SFC_ADDR, 8'h0A);
        rx_chk(`SAR_SFC_ADDR, 8'h0A, "format write");
        avs_xfer(1'h0, 4'h0, 32'h0, rd);
        check(rd, {25'h0, `SAR_HOST_CTRL_RESET}, "ctrl reset");
    endtask
    // Rows are {format, word length, ratio}: every code of each field appears
    task automatic t_format_sweep();
        logic [5:0] cfg[9] = '{6'h15, 6'h10, 6'h1A, 6'h26, 6'h21, 6'h05, 6'h02, 6'h0A,
            6'h3F};
        logic [23:0] lv[3] = '{24'hF12345, 24'h7EDCBA, 24'h80F0F1};
        logic [23:0] rv[3] = '{24'h123457, 24'hC0FFEE, 24'h7FFFFF};
        logic [23:0] mask;
        logic [31:0] rd;
        int j;
        foreach (cfg[i])
        begin
            do_reset();
            rx_wr(`SAR_SFC_ADDR, {4'h0, cfg[i][5:2]});
            avs_xfer(1'h1, 4'h0, {25'h0, cfg[i][1:0], cfg[i][3:2], cfg[i][5:4], 1'h1}, rd);
            mask = (cfg[i][3:2] == 2'h0) ? 24'hFFFF00 :
                (cfg[i][3:2] == 2'h2) ? 24'hFFFFF0 : 24'hFFFFFF;
            // Let the partial first pair pass before real samples go out
            repeat (1200) @(posedge sys_clk);
            for (int k = 0; k < 3; k++)
            begin
                avs_xfer(1'h1, 4'h4, {8'h00, lv[k]}, rd);
                avs_xfer(1'h1, 4'h8, {8'h00, rv[k]}, rd);
            end
            repeat (2000) @(posedge sys_clk);
            j = 1;
            while (j < cap_l.size() && cap_l[j] == 24'h0)
                j++;
            for (int k = 0; k < 3; k++)
            begin
                check(cap_l[j + k], lv[k] & mask, "left");
                check(cap_r[j + k], rv[k] & mask, "right");
            end
            check(n_strobe, cap_l.size(), "strobe count");
        end
    endtask
    task automatic t_stall();
        logic [31:0] rd;
        do_reset();
        out_ready <= 1'h0;
        avs_xfer(1'h1, 4'h0, 32'h0000000B, rd);
        repeat (2500) @(posedge sys_clk);
        check(out_valid, 32'h1, "buffer full");
        rx_chk(`SAR_ERR_ADDR, 8'h01, "overflow set");
        out_ready <= 1'h1;
        repeat (4) @(posedge sys_clk);
        check(out_valid, 32'h0, "buffer empty");
        rx_wr(`SAR_ERR_ADDR, 8'h01);
        rx_chk(`SAR_ERR_ADDR, 8'h00, "overflow clear");
    endtask
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end
    initial
    begin
        sys_clk = 1'h0;
        rst_b = 1'h0;
        avs_address = 4'h0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        reg_wr = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        out_ready = 1'h1;
        mismatches = 0;
        n_tests = 0;
        @(posedge sys_clk);
        t_regs();
        t_format_sweep();
        t_stall();
        test_done();
    end
endmodule // tb_top
